/* File: logic/sxle_regs.svh */
// Purpose: Register indices, field positions and reset values for the
//          serial extra lane enable block.
// Assumes: Register index times four is the byte address on the bus.
// Notes:   Definitions only.
`ifndef SXLE_REGS_SVH
`define SXLE_REGS_SVH

`define SXLE_IDX_W 10
`define SXLE_IDX_CTRL 10'h1F0
`define SXLE_IDX_MODE 10'h1F1
`define SXLE_IDX_TEST 10'h1F2
`define SXLE_IDX_STAT 10'h1F3
`define SXLE_IDX_PD 10'h209
`define SXLE_IDX_XA 10'h20A
`define SXLE_IDX_XB 10'h20B

`define SXLE_ADR_LO 2
`define SXLE_ADR_HI 11

`define SXLE_CTRL_EN_BIT 0
`define SXLE_CTRL_REFUSED_BIT 1
`define SXLE_PD_A_BIT 0
`define SXLE_PD_B_BIT 1
`define SXLE_XL_SER_BIT 0
`define SXLE_XL_LANE_LO 1
`define SXLE_XL_LANE_HI 7

`define SXLE_RST_XL 8'h00
`define SXLE_RST_PD 2'h0
`define SXLE_RST_MODE 8'h00
`define SXLE_RST_TEST 8'h00
`define SXLE_RST_EN 1'h0
`define SXLE_RST_FLAG 1'h0
`define SXLE_RST_LANES 8'h00
`define SXLE_ZERO32 32'h0000_0000
`define SXLE_ZERO24 24'h00_0000
`define SXLE_ZERO22 22'h00_0000
`define SXLE_ZERO6 6'h00

`endif

/* File: logic/sxle_pkg.sv */
// Purpose: Types shared by the serial extra lane enable block.
// Assumes: At most eight lanes per link.
// Notes:   Offsets and reset values live in sxle_regs.svh.
package sxle_pkg;

  localparam int SXLE_MAX_LANES = 8;

  // One link's extra lane register: lanes 7..1 plus the serializer bit
  typedef struct packed {
    logic [7:1] lanes;
    logic ser;
  } sxle_extra_s;

  // Per-lane enables driven toward one link's lanes
  typedef struct packed {
    logic [7:0] ser_en;
    logic [7:0] clk_en;
  } sxle_lanes_s;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sxle_wb_req_s;

endpackage : sxle_pkg

/* File: logic/sxle_lane_gate.sv */
// Purpose: Lane clock and serializer enables for one link.
// Assumes: mode_mask comes from the link mode decoder on the same clock.
// Notes:   Purely combinational; the top registers the result.
`timescale 1ns/10ps
module sxle_lane_gate #(
  parameter int LANES = 8
) (
  input wire logic [7:0] mode_mask,
  input wire sxle_pkg::sxle_extra_s extra,
  input wire logic link_active,
  output sxle_pkg::sxle_lanes_s lanes
);
  import sxle_pkg::*;

  if (LANES < 1 || LANES > SXLE_MAX_LANES)
  begin : g_bad_lanes
    $error("sxle_lane_gate: LANES must lie between 1 and 8");
  end

  logic [7:0] want_clk;
  logic [7:0] want_ser;
  logic [7:0] chain;
  logic [7:0] clk_en;

  assign chain[0] = 1'b1;

  for (genvar i = 0; i < SXLE_MAX_LANES; i++)
  begin : g_lane
    if (i >= LANES)
    begin : g_absent
      assign want_clk[i] = 1'b0;
      assign want_ser[i] = 1'b0;
    end
    else if (i == 0)
    begin : g_base
      // Lane 0 has no extra bit; only the link mode can use it
      assign want_clk[i] = mode_mask[i];
      assign want_ser[i] = mode_mask[i];
    end
    else
    begin : g_extra
      assign want_clk[i] = mode_mask[i] | extra.lanes[i];
      // Clock-only extra lanes keep their serializer off
      assign want_ser[i] = mode_mask[i] | (extra.ser & extra.lanes[i]);
    end
    assign clk_en[i] = link_active & want_clk[i];
    if (i < SXLE_MAX_LANES - 1)
    begin : g_next
      assign chain[i + 1] = chain[i] & clk_en[i];
    end
    // A serializer gets its clock only if every lower lane is clocked
    assign lanes.ser_en[i] = clk_en[i] & want_ser[i] & chain[i];
  end

  assign lanes.clk_en = clk_en;

endmodule : sxle_lane_gate

/* File: logic/sxle_top.sv */
// Purpose: Extra transmit lane enables for links A and B, with the
//          channel power-down and global link controls, on Wishbone.
// Assumes: Classic Wishbone, 32-bit data, byte address = index * 4.
// Notes:   Every output comes from a flip-flop; one clock domain.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
`include "sxle_regs.svh"

// Functional notes
// - Link A bits 7..1 enable lanes A1..A7
// - Link B bits 7..1 enable lanes B1..B7
// - Extra lane enabled even if mode unused
// - Bit 0 also enables extra serializers
// - Extra lanes follow global mode and test
// - Powered-down link keeps extra lanes inactive
// - Serializer n needs lanes 0..n-1 enabled
// - Both extra lane registers reset to zero
// - Power-down bits per channel; both kill subsystem
module sxle_top #(
  parameter int LANES = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire sxle_pkg::sxle_wb_req_s wb_req,
  input wire logic [7:0] mode_lanes_a,
  input wire logic [7:0] mode_lanes_b,
  output logic wb_ack,
  output logic [31:0] wb_dat_o,
  output sxle_pkg::sxle_lanes_s lanes_a,
  output sxle_pkg::sxle_lanes_s lanes_b,
  output logic [7:0] link_mode_select,
  output logic [7:0] link_test_pattern_select,
  output logic serial_link_enable,
  output logic [1:0] channel_power_down,
  output logic subsystem_power_down
);
  import sxle_pkg::*;

  if (LANES < 2 || LANES > SXLE_MAX_LANES)
  begin : g_bad_lanes
    $error("sxle_top: LANES must lie between 2 and 8");
  end

  // Bus decode

  logic [`SXLE_IDX_W-1:0] idx;
  logic req;
  logic new_req;
  logic wr;
  logic hit_ctrl;
  logic hit_mode;
  logic hit_test;
  logic hit_stat;
  logic hit_pd;
  logic hit_xa;
  logic hit_xb;
  logic hit_guarded;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_test;
  logic wr_pd;
  logic wr_xa;
  logic wr_xb;
  logic refuse_evt;
  logic refused_clr;

  assign idx = wb_req.adr[`SXLE_ADR_HI:`SXLE_ADR_LO];
  assign req = wb_req.cyc & wb_req.stb;
  // Ack drops for a cycle after each answer, so one request, one effect
  assign new_req = req & ~wb_ack;
  // All writable registers live in byte lane 0
  assign wr = new_req & wb_req.we & wb_req.sel[0];

  assign hit_ctrl = (idx == `SXLE_IDX_CTRL);
  assign hit_mode = (idx == `SXLE_IDX_MODE);
  assign hit_test = (idx == `SXLE_IDX_TEST);
  assign hit_stat = (idx == `SXLE_IDX_STAT);
  assign hit_pd = (idx == `SXLE_IDX_PD);
  assign hit_xa = (idx == `SXLE_IDX_XA);
  assign hit_xb = (idx == `SXLE_IDX_XB);
  assign hit_guarded = hit_pd | hit_xa | hit_xb;

  // Lane and power settings must not move under a running link, so
  // such writes are dropped and flagged rather than half-applied.
  assign wr_pd = wr & hit_pd & ~serial_link_enable;
  assign wr_xa = wr & hit_xa & ~serial_link_enable;
  assign wr_xb = wr & hit_xb & ~serial_link_enable;
  assign refuse_evt = wr & hit_guarded & serial_link_enable;
  assign wr_ctrl = wr & hit_ctrl;
  assign wr_mode = wr & hit_mode;
  assign wr_test = wr & hit_test;
  assign refused_clr = wr_ctrl & wb_req.dat[`SXLE_CTRL_REFUSED_BIT];

  // Register storage

  sxle_extra_s extra_a;
  sxle_extra_s extra_b;
  logic refused;

  sxle_extra_s next_extra_a;
  sxle_extra_s next_extra_b;
  logic [1:0] next_pd;
  logic next_link_en;
  logic [7:0] next_mode;
  logic [7:0] next_test;
  logic next_refused;

  assign next_extra_a = wr_xa ? sxle_extra_s'(wb_req.dat[7:0]) : extra_a;
  assign next_extra_b = wr_xb ? sxle_extra_s'(wb_req.dat[7:0]) : extra_b;
  assign next_pd = wr_pd ? wb_req.dat[`SXLE_PD_B_BIT:`SXLE_PD_A_BIT]
                         : channel_power_down;
  assign next_link_en = wr_ctrl ? wb_req.dat[`SXLE_CTRL_EN_BIT]
                                : serial_link_enable;
  assign next_mode = wr_mode ? wb_req.dat[7:0] : link_mode_select;
  assign next_test = wr_test ? wb_req.dat[7:0] : link_test_pattern_select;
  // A new refusal in the clearing cycle survives the clear
  assign next_refused = refuse_evt | (refused & ~refused_clr);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extra_a <= `SXLE_RST_XL;
      extra_b <= `SXLE_RST_XL;
    end
    else
    begin
      extra_a <= next_extra_a;
      extra_b <= next_extra_b;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      channel_power_down <= `SXLE_RST_PD;
      subsystem_power_down <= `SXLE_RST_FLAG;
    end
    else
    begin
      channel_power_down <= next_pd;
      subsystem_power_down <= &next_pd;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_link_enable <= `SXLE_RST_EN;
      refused <= `SXLE_RST_FLAG;
    end
    else
    begin
      serial_link_enable <= next_link_en;
      refused <= next_refused;
    end
  end

  // Extra lanes have no rate or mode of their own: they share these
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_mode_select <= `SXLE_RST_MODE;
      link_test_pattern_select <= `SXLE_RST_TEST;
    end
    else
    begin
      link_mode_select <= next_mode;
      link_test_pattern_select <= next_test;
    end
  end

  // Lane gating

  logic link_act_a;
  logic link_act_b;
  sxle_lanes_s gate_a;
  sxle_lanes_s gate_b;

  // A link runs only when enabled, its channel is up and the
  // whole subsystem is not powered down.
  assign link_act_a = serial_link_enable
                    & ~channel_power_down[`SXLE_PD_A_BIT]
                    & ~subsystem_power_down;
  assign link_act_b = serial_link_enable
                    & ~channel_power_down[`SXLE_PD_B_BIT]
                    & ~subsystem_power_down;

  sxle_lane_gate #(
    .LANES(LANES)
  ) u_gate_a (
    .mode_mask(mode_lanes_a),
    .extra(extra_a),
    .link_active(link_act_a),
    .lanes(gate_a)
  );

  sxle_lane_gate #(
    .LANES(LANES)
  ) u_gate_b (
    .mode_mask(mode_lanes_b),
    .extra(extra_b),
    .link_active(link_act_b),
    .lanes(gate_b)
  );

  // Registered so lane enables never glitch toward the serializers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lanes_a <= {`SXLE_RST_LANES, `SXLE_RST_LANES};
      lanes_b <= {`SXLE_RST_LANES, `SXLE_RST_LANES};
    end
    else
    begin
      lanes_a <= gate_a;
      lanes_b <= gate_b;
    end
  end

  // Read path

  logic [31:0] rd_ctrl;
  logic [31:0] rd_mode;
  logic [31:0] rd_test;
  logic [31:0] rd_stat;
  logic [31:0] rd_pd;
  logic [31:0] rd_xa;
  logic [31:0] rd_xb;
  logic [31:0] rd_data;

  assign rd_ctrl = {`SXLE_ZERO24, `SXLE_ZERO6, refused, serial_link_enable};
  assign rd_mode = {`SXLE_ZERO24, link_mode_select};
  assign rd_test = {`SXLE_ZERO24, link_test_pattern_select};
  assign rd_stat = {lanes_b.ser_en, lanes_b.clk_en,
                    lanes_a.ser_en, lanes_a.clk_en};
  assign rd_pd = {`SXLE_ZERO24, `SXLE_ZERO6, channel_power_down};
  assign rd_xa = {`SXLE_ZERO24, extra_a};
  assign rd_xb = {`SXLE_ZERO24, extra_b};

  // Unmapped addresses read as zero and ignore writes
  assign rd_data = hit_ctrl ? rd_ctrl :
                   hit_mode ? rd_mode :
                   hit_test ? rd_test :
                   hit_stat ? rd_stat :
                   hit_pd ? rd_pd :
                   hit_xa ? rd_xa :
                   hit_xb ? rd_xb :
                   `SXLE_ZERO32;

  // One wait state: ack in the cycle after the request is seen
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack <= 1'b0;
      wb_dat_o <= `SXLE_ZERO32;
    end
    else
    begin
      wb_ack <= new_req;
      wb_dat_o <= new_req ? rd_data : `SXLE_ZERO32;
    end
  end

endmodule : sxle_top

/* File: bench/sxle_top_sva.sv */
// Purpose: Port checks for sxle_top
// Assumes: One clock, rst_n async low
// Notes: Bound to every sxle_top
`timescale 1ns/10ps
module sxle_top_sva
  import sxle_pkg::*;
#(
  parameter int LANES = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire sxle_pkg::sxle_wb_req_s wb_req,
  input wire logic wb_ack,
  input wire logic [31:0] wb_dat_o,
  input wire sxle_pkg::sxle_lanes_s lanes_a,
  input wire sxle_pkg::sxle_lanes_s lanes_b,
  input wire logic serial_link_enable,
  input wire logic [1:0] channel_power_down,
  input wire logic subsystem_power_down
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Lanes with an unbroken run of clocks from lane 0
  wire logic [7:0] run_a = lanes_a.clk_en & ~(lanes_a.clk_en + 8'h01);
  wire logic [7:0] run_b = lanes_b.clk_en & ~(lanes_b.clk_en + 8'h01);
  property p_ack;
    wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse;
    wb_ack |=> !wb_ack;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_dat;
    !wb_ack |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dat: assert property (p_dat) else $error("data without ack");
  // One cycle of lag allowed for the registered gate
  property p_off;
    !serial_link_enable && !$past(serial_link_enable)
      |-> lanes_a == 16'h0000 && lanes_b == 16'h0000;
  endproperty
  a_off: assert property (p_off) else $error("lanes while off");
  property p_pd_a;
    channel_power_down[0] && $past(channel_power_down[0])
      |-> lanes_a == 16'h0000;
  endproperty
  a_pd_a: assert property (p_pd_a) else $error("link a down");
  property p_pd_b;
    channel_power_down[1] && $past(channel_power_down[1])
      |-> lanes_b == 16'h0000;
  endproperty
  a_pd_b: assert property (p_pd_b) else $error("link b down");
  property p_sub;
    subsystem_power_down == (&channel_power_down);
  endproperty
  a_sub: assert property (p_sub) else $error("subsystem");
  property p_ser;
    (lanes_a.ser_en & ~lanes_a.clk_en) == 8'h00
      && (lanes_b.ser_en & ~lanes_b.clk_en) == 8'h00;
  endproperty
  a_ser: assert property (p_ser) else $error("ser no clk");
  property p_run;
    (lanes_a.ser_en & ~run_a) == 8'h00 && (lanes_b.ser_en & ~run_b) == 8'h00;
  endproperty
  a_run: assert property (p_run) else $error("ser gap");
  c_ser: cover property (lanes_a.ser_en[3]);
  c_sub: cover property (subsystem_power_down);
  c_wr: cover property (wb_req.we && wb_ack);
endmodule : sxle_top_sva

bind sxle_top sxle_top_sva #(.LANES(LANES)) u_sxle_top_sva (
  .clk(clk),
  .rst_n(rst_n),
  .wb_req(wb_req),
  .wb_ack(wb_ack),
  .wb_dat_o(wb_dat_o),
  .lanes_a(lanes_a),
  .lanes_b(lanes_b),
  .serial_link_enable(serial_link_enable),
  .channel_power_down(channel_power_down),
  .subsystem_power_down(subsystem_power_down)
);

/* File: bench/sxle_rx_model.sv */
// Purpose: Receiver side: counts lanes that carry data
// Assumes: Only serializer-enabled lanes transmit
// Notes: No reset, counts settle after one clock
`timescale 1ns/10ps
module sxle_rx_model
  import sxle_pkg::*;
(
  input wire logic clk,
  input wire sxle_pkg::sxle_lanes_s lanes_a,
  input wire sxle_pkg::sxle_lanes_s lanes_b,
  output logic [3:0] data_a,
  output logic [3:0] data_b
);
  // Clock-only lanes are silent, so they do not count
  always_ff @(posedge clk)
  begin
    data_a <= 4'($countones(lanes_a.ser_en));
    data_b <= 4'($countones(lanes_b.ser_en));
  end
endmodule : sxle_rx_model

/* File: bench/tb.sv */
// Purpose: Register and lane tests for sxle_top
// Assumes: The slave answers every request; the watchdog ends a hang
// Notes: Lane fields checked two cycles after the write
`timescale 1ns/10ps
`include "sxle_regs.svh"
module tb;
  import sxle_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sxle_wb_req_s wb_req = '0;
  logic [7:0] m_a = 8'h01;
  logic [7:0] m_b = 8'h01;
  logic wb_ack;
  logic [31:0] wb_dat_o;
  sxle_lanes_s lanes_a;
  sxle_lanes_s lanes_b;
  logic [7:0] lms;
  logic [7:0] lts;
  logic sle;
  logic [1:0] cpd;
  logic spd;
  logic [3:0] data_a;
  logic [3:0] data_b;
  logic [31:0] rdat;
  logic [9:0] ridx [4] = '{`SXLE_IDX_XA, `SXLE_IDX_XB, `SXLE_IDX_PD,
    `SXLE_IDX_CTRL};
  int errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  sxle_top u_sxle_top (.clk(clk), .rst_n(rst_n), .wb_req(wb_req),
    .mode_lanes_a(m_a), .mode_lanes_b(m_b), .wb_ack(wb_ack),
    .wb_dat_o(wb_dat_o), .lanes_a(lanes_a), .lanes_b(lanes_b),
    .link_mode_select(lms), .link_test_pattern_select(lts),
    .serial_link_enable(sle), .channel_power_down(cpd),
    .subsystem_power_down(spd));
  sxle_rx_model u_sxle_rx_model (.clk(clk), .lanes_a(lanes_a),
    .lanes_b(lanes_b), .data_a(data_a), .data_b(data_b));
  task automatic stop_test;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %0h want %0h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [9:0] idx,
    input logic [7:0] d);
    @(posedge clk);
    wb_req <= {2'b11, we, idx, 2'b00, 4'hF, 24'h00_0000, d};
    // No cycle count assumed: only the watchdog ends a missing ack
    do
    begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    rdat = wb_dat_o;
    wb_req <= '0;
    @(posedge clk);
    chk(32'h0000_0001, {31'h0, wb_ack === 1'b0});
  endtask : bus
  task automatic lanes(input logic [15:0] ea, input logic [15:0] eb);
    repeat (2) @(posedge clk);
    chk({16'h0000, ea}, {16'h0000, lanes_a});
    chk({16'h0000, eb}, {16'h0000, lanes_b});
  endtask : lanes
  initial
  begin
    #20000;
    errors++;
    $display("unexpected at %0t: timeout", $time);
    stop_test();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ridx[i])
    begin
      bus(1'b0, ridx[i], 8'h00);
      chk(32'h0000_0000, rdat);
    end
    $display("test reset done");
    bus(1'b1, `SXLE_IDX_XA, 8'h0E);
    bus(1'b1, `SXLE_IDX_CTRL, 8'h01);
    lanes(16'h010F, 16'h0101);
    chk(32'h0000_0001, {28'h0, data_a});
    bus(1'b0, `SXLE_IDX_XA, 8'h00);
    chk(32'h0000_000E, rdat);
    $display("test clocks done");
    bus(1'b1, `SXLE_IDX_CTRL, 8'h00);
    bus(1'b1, `SXLE_IDX_XA, 8'h0F);
    bus(1'b1, `SXLE_IDX_XB, 8'hAB);
    bus(1'b1, `SXLE_IDX_CTRL, 8'h01);
    lanes(16'h0F0F, 16'h03AB);
    chk(32'h0000_0004, {28'h0, data_a});
    chk(32'h0000_0002, {28'h0, data_b});
    bus(1'b0, `SXLE_IDX_STAT, 8'h00);
    chk(32'h03AB_0F0F, rdat);
    bus(1'b0, `SXLE_IDX_XB, 8'h00);
    chk(32'h0000_00AB, rdat);
    $display("test serializers done");
    bus(1'b1, `SXLE_IDX_XA, 8'h00);
    bus(1'b0, `SXLE_IDX_XA, 8'h00);
    chk(32'h0000_000F, rdat);
    bus(1'b0, `SXLE_IDX_CTRL, 8'h00);
    chk(32'h0000_0003, rdat);
    bus(1'b1, `SXLE_IDX_CTRL, 8'h02);
    bus(1'b0, `SXLE_IDX_CTRL, 8'h00);
    chk(32'h0000_0000, rdat);
    $display("test refused done");
    bus(1'b1, `SXLE_IDX_PD, 8'h01);
    bus(1'b1, `SXLE_IDX_CTRL, 8'h01);
    lanes(16'h0000, 16'h03AB);
    chk(32'h0000_0000, {31'h0, spd});
    chk(32'h0000_0001, {30'h0, cpd});
    chk(32'h0000_0001, {31'h0, sle});
    bus(1'b1, `SXLE_IDX_CTRL, 8'h00);
    bus(1'b1, `SXLE_IDX_PD, 8'h03);
    bus(1'b0, `SXLE_IDX_PD, 8'h00);
    chk(32'h0000_0003, rdat);
    bus(1'b1, `SXLE_IDX_CTRL, 8'h01);
    lanes(16'h0000, 16'h0000);
    chk(32'h0000_0001, {31'h0, spd});
    chk(32'h0000_0003, {30'h0, cpd});
    $display("test power down done");
    bus(1'b1, `SXLE_IDX_MODE, 8'h5A);
    bus(1'b1, `SXLE_IDX_TEST, 8'h3C);
    chk(32'h0000_3C5A, {16'h0000, lts, lms});
    bus(1'b0, 10'h100, 8'h00);
    chk(32'h0000_0000, rdat);
    $display("test mode done");
    // Reset in mid-run, with the link enabled and both channels down
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    lanes(16'h0000, 16'h0000);
    foreach (ridx[i])
    begin
      bus(1'b0, ridx[i], 8'h00);
      chk(32'h0000_0000, rdat);
    end
    $display("test second reset done");
    // Lane 0 unused by the mode breaks every serializer above it
    m_a <= 8'h00;
    bus(1'b1, `SXLE_IDX_XA, 8'h0F);
    bus(1'b1, `SXLE_IDX_CTRL, 8'h01);
    lanes(16'h000E, 16'h0101);
    chk(32'h0000_0000, {28'h0, data_a});
    chk(32'h0000_0001, {28'h0, data_b});
    $display("test lane zero done");
    stop_test();
  end
endmodule : tb
